// [mpg_defines.svh]
// Purpose: Constants of the pause frame generator
// Assumes: Byte index 0 is the first preamble octet
// Notes: Functional notes below
//
// Functional notes
// RULE1 - Type field after source address is 0x8808
// RULE2 - Opcode 0x0001 follows the type field
// RULE3 - Two-octet quanta directly follows the opcode
// RULE4 - Quanta high byte sent before low byte
// RULE5 - No length field; 42 zero pads, CRC
// RULE6 - Flow control enable gates all five triggers
// RULE7 - Fill level reaching threshold triggers XOFF frame
// RULE8 - XOFF request alone repeats XOFF frames
// RULE9 - XON request alone repeats XON frames
// RULE10 - Controller never raises XOFF and XON together
// RULE11 - Controller raises threshold when using manual requests
// RULE12 - Controller uses either pins or register bits
// RULE13 - Preamble 0x55 octets, then one 0xd5 delimiter
// RULE14 - XOFF carries configured quanta, XON carries zero
// RULE15 - Finish current frame first, never interleave octets
`ifndef MPG_DEFINES_SVH
`define MPG_DEFINES_SVH
`define MPG_PREAMBLE 8'h55
`define MPG_SOF_DELIM 8'hd5
`define MPG_TYPE 16'h8808
`define MPG_OPCODE 16'h0001
`define MPG_PAD 8'h00
// Reserved control multicast, least significant byte goes first
`define MPG_DEST_ADDR 48'h010000c28001
`define MPG_IDX_SOF 7'h07
`define MPG_IDX_DA 7'h08
`define MPG_IDX_SA 7'h0e
`define MPG_IDX_TYPE 7'h14
`define MPG_IDX_OPC 7'h16
`define MPG_IDX_QNT 7'h18
`define MPG_IDX_PAD 7'h1a
`define MPG_IDX_CRC 7'h44
`define MPG_IDX_LAST 7'h47
`define MPG_IPG_BYTES 4'hc
`define MPG_CRC_INIT 32'hffffffff
`define MPG_CRC_POLY 32'hedb88320
`endif

// [mpg_pause_gen.sv]
// Purpose: Pause frame generator on the MAC transmit path
// Assumes: TX_CLK is a sampled link clock well below SYS_CLK/2
// Notes: Client frames pass through; pause frames go between them
`timescale 1ns/1ps
`include "mpg_defines.svh"
module mpg_pause_gen
  import mpg_pkg::*;
#(
  parameter int FILL_W = 12
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic TX_CLK,
  input wire logic GIG_MODE,
  input wire logic FC_ENA,
  input wire logic XOFF_REG,
  input wire logic XON_REG,
  input wire logic XOFF_PIN,
  input wire logic XON_PIN,
  input wire logic [FILL_W-1:0] RX_FILL_LEVEL,
  input wire logic [FILL_W-1:0] RX_SECTION_EMPTY,
  input wire logic [15:0] PAUSE_QUANTA,
  input wire logic [47:0] SRC_ADDR,
  input wire mpg_octet_s CLI_TX,
  output logic CLI_READY,
  output logic [7:0] TXD,
  output logic TX_EN,
  output logic PAUSE_ACTIVE
);

  ////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  logic [1:0] rst_q;
  logic rst_n;
  logic [2:0] clk_s;
  logic [1:0] xoff_s;
  logic [1:0] xon_s;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Third stage of the clock chain only feeds the edge detector
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clk_s <= 3'h0;
      xoff_s <= 2'h0;
      xon_s <= 2'h0;
    end else begin
      clk_s <= {clk_s[1:0], TX_CLK};
      xoff_s <= {xoff_s[0], XOFF_PIN};
      xon_s <= {xon_s[0], XON_PIN};
    end
  end

  logic tick;
  assign tick = clk_s[1] & ~clk_s[2];

  ////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `MPG_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [6:0] off);
    logic [47:0] s;
    s = a >> {off, 3'h0};
    return s[7:0];
  endfunction : addr_byte

  ////////////////////////////////////////////////////////////////////
  // Triggers
  logic above;
  logic above_q;
  logic auto_pend;
  logic next_above_q;
  logic next_auto_pend;
  mpg_req_s want;
  logic start_pause;
  logic start_xon;

  assign above = RX_FILL_LEVEL >= RX_SECTION_EMPTY; // [RULE7]
  // Register bits and pins merge; the controller keeps one set idle [RULE12]
  always_comb begin
    want.xoff = FC_ENA & (XOFF_REG | xoff_s[1] | auto_pend); // [RULE6] [RULE8]
    want.xon = FC_ENA & (XON_REG | xon_s[1]); // [RULE6] [RULE9]
  end

  always_comb begin
    next_above_q = above;
    next_auto_pend = auto_pend;
    if (start_pause && !start_xon) begin
      next_auto_pend = 1'b0;
    end
    // A new crossing in the start cycle still counts
    if (FC_ENA && above && !above_q) begin
      next_auto_pend = 1'b1; // [RULE7]
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      above_q <= 1'b0;
      auto_pend <= 1'b0;
    end else begin
      above_q <= next_above_q;
      auto_pend <= next_auto_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Octet sequencer
  mpg_state_e state;
  mpg_state_e next_state;
  logic [6:0] idx;
  logic [6:0] next_idx;
  logic [3:0] gap;
  logic [3:0] next_gap;
  logic kind_xon;
  logic next_kind_xon;
  logic [31:0] crc;
  logic [31:0] next_crc;
  mpg_octet_s octet;
  mpg_octet_s next_octet;
  logic phase;
  logic adv;
  logic [15:0] quanta;
  logic [7:0] pb;
  logic [31:0] fcs;

  // MII needs two ticks per octet, low nibble first
  assign adv = tick & (GIG_MODE | phase);
  // Both requests at once resolve to XOFF
  assign start_pause = adv && state == ST_IDLE && (want.xoff || want.xon);
  assign start_xon = ~want.xoff;
  assign quanta = kind_xon ? 16'h0000 : PAUSE_QUANTA; // [RULE14]
  assign fcs = ~crc;

  always_comb begin
    pb = `MPG_PAD; // [RULE5]
    if (idx < `MPG_IDX_SOF) begin
      pb = `MPG_PREAMBLE; // [RULE13]
    end else if (idx == `MPG_IDX_SOF) begin
      pb = `MPG_SOF_DELIM; // [RULE13]
    end else if (idx < `MPG_IDX_SA) begin
      pb = addr_byte(`MPG_DEST_ADDR, idx - `MPG_IDX_DA);
    end else if (idx < `MPG_IDX_TYPE) begin
      pb = addr_byte(SRC_ADDR, idx - `MPG_IDX_SA);
    end else if (idx == `MPG_IDX_TYPE) begin
      pb = 8'(`MPG_TYPE >> 8); // [RULE1]
    end else if (idx == `MPG_IDX_TYPE + 7'h01) begin
      pb = 8'(`MPG_TYPE); // [RULE1]
    end else if (idx == `MPG_IDX_OPC) begin
      pb = 8'(`MPG_OPCODE >> 8); // [RULE2]
    end else if (idx == `MPG_IDX_OPC + 7'h01) begin
      pb = 8'(`MPG_OPCODE); // [RULE2]
    end else if (idx == `MPG_IDX_QNT) begin
      pb = quanta[15:8]; // [RULE3] [RULE4]
    end else if (idx == `MPG_IDX_QNT + 7'h01) begin
      pb = quanta[7:0]; // [RULE3] [RULE4]
    end else if (idx >= `MPG_IDX_CRC) begin
      // CRC field starts on a multiple of four, so the low index bits pick the byte
      pb = fcs[{idx[1:0], 3'h0} +: 8]; // [RULE5]
    end
  end

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_gap = gap;
    next_kind_xon = kind_xon;
    next_crc = crc;
    next_octet = octet;
    if (adv) begin
      case (state)
        ST_IDLE: begin
          next_octet = '0;
          next_crc = `MPG_CRC_INIT;
          next_idx = 7'h00;
          // Pause frames only start between client frames [RULE15]
          if (start_pause) begin
            next_state = ST_PAUSE;
            next_kind_xon = start_xon;
          end else if (CLI_TX.en) begin
            next_state = ST_CLIENT;
            next_octet = CLI_TX;
          end
        end
        ST_CLIENT: begin
          next_octet = CLI_TX;
          if (!CLI_TX.en) begin
            next_state = ST_GAP;
            next_gap = 4'h0;
          end
        end
        ST_PAUSE: begin
          next_octet = '{en: 1'b1, data: pb};
          next_idx = idx + 7'h01;
          if (idx >= `MPG_IDX_DA && idx < `MPG_IDX_CRC) begin
            next_crc = crc_byte(crc, pb);
          end
          // Whole frame always completes [RULE15]
          if (idx == `MPG_IDX_LAST) begin
            next_state = ST_GAP;
            next_gap = 4'h0;
          end
        end
        ST_GAP: begin
          next_octet = '0;
          next_gap = gap + 4'h1;
          // Idle state rechecks requests, so held ones repeat [RULE8] [RULE9]
          if (gap == `MPG_IPG_BYTES - 4'h1) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      idx <= 7'h00;
      gap <= 4'h0;
      kind_xon <= 1'b0;
      crc <= `MPG_CRC_INIT;
      octet <= '0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      gap <= next_gap;
      kind_xon <= next_kind_xon;
      crc <= next_crc;
      octet <= next_octet;
    end
  end

  // Client is taken on adv while idle with nothing pending, or mid-frame
  assign CLI_READY = (state == ST_IDLE && !(want.xoff || want.xon)) || state == ST_CLIENT;

  ////////////////////////////////////////////////////////////////////
  // Pin stage
  logic next_phase;
  logic [7:0] next_txd;
  logic next_tx_en;
  logic next_active;

  always_comb begin
    next_phase = phase;
    next_txd = TXD;
    next_tx_en = TX_EN;
    next_active = state == ST_PAUSE;
    if (tick) begin
      next_phase = ~phase;
      next_tx_en = octet.en;
      if (GIG_MODE) begin
        next_txd = octet.data;
      end else begin
        next_txd = {4'h0, phase ? octet.data[7:4] : octet.data[3:0]};
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      TXD <= 8'h00;
      TX_EN <= 1'b0;
      PAUSE_ACTIVE <= 1'b0;
    end else begin
      phase <= next_phase;
      TXD <= next_txd;
      TX_EN <= next_tx_en;
      PAUSE_ACTIVE <= next_active;
    end
  end

endmodule : mpg_pause_gen

// [mpg_pause_gen_properties.sv]
// Purpose: Port assertions of the pause frame generator
// Assumes: One clock domain, RST_N low resets
// Notes: Bound to every mpg_pause_gen
`timescale 1ns/1ps
module mpg_pause_gen_properties
  import mpg_pkg::*;
#(
  parameter int FILL_W = 12
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic GIG_MODE,
  input wire logic FC_ENA,
  input wire logic XOFF_REG,
  input wire logic XON_REG,
  input wire logic XOFF_PIN,
  input wire logic XON_PIN,
  input wire logic [FILL_W-1:0] RX_FILL_LEVEL,
  input wire logic [FILL_W-1:0] RX_SECTION_EMPTY,
  input wire logic CLI_READY,
  input wire logic [7:0] TXD,
  input wire logic TX_EN,
  input wire logic PAUSE_ACTIVE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  reset_quiet_a: assert property ($rose(RST_N) |-> (!TX_EN && !PAUSE_ACTIVE) [*2])
    else $error("Transmit active after reset");
  fc_gate_a: assert property ((!FC_ENA && !PAUSE_ACTIVE) [*4] |=> !PAUSE_ACTIVE)
    else $error("Pause frame with flow control off");
  req_start_a: assert property ($rose(XOFF_REG | XON_REG | XOFF_PIN | XON_PIN) && FC_ENA && !TX_EN
    |-> ##[1:700] PAUSE_ACTIVE)
    else $error("Request did not start a pause frame");
  fill_start_a: assert property ($rose(RX_FILL_LEVEL >= RX_SECTION_EMPTY) && FC_ENA && !TX_EN
    |-> ##[1:700] PAUSE_ACTIVE)
    else $error("Threshold did not start a pause frame");
  held_repeat_a: assert property ($fell(PAUSE_ACTIVE) && FC_ENA && (XOFF_REG || XON_REG)
    |-> ##[1:700] PAUSE_ACTIVE)
    else $error("Held request did not repeat");
  preamble_first_a: assert property ($rose(TX_EN) && PAUSE_ACTIVE
    |-> TXD == (GIG_MODE ? 8'h55 : 8'h05))
    else $error("Pause frame does not open with preamble");
  client_hold_a: assert property (PAUSE_ACTIVE |-> !CLI_READY)
    else $error("Client accepted during pause frame");
  gap_after_a: assert property ($fell(TX_EN) |-> !TX_EN [*8])
    else $error("Frames too close together");
  gig_frame_c: cover property ($rose(PAUSE_ACTIVE) && GIG_MODE);
  mii_frame_c: cover property ($rose(PAUSE_ACTIVE) && !GIG_MODE);
  fill_trig_c: cover property ($rose(RX_FILL_LEVEL >= RX_SECTION_EMPTY) && FC_ENA);
  client_wait_c: cover property ($fell(CLI_READY) && TX_EN && !PAUSE_ACTIVE);
endmodule : mpg_pause_gen_properties
bind mpg_pause_gen mpg_pause_gen_properties #(.FILL_W(FILL_W)) i_mpg_pause_gen_properties (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .GIG_MODE(GIG_MODE), .FC_ENA(FC_ENA), .XOFF_REG(XOFF_REG),
  .XON_REG(XON_REG), .XOFF_PIN(XOFF_PIN), .XON_PIN(XON_PIN), .RX_FILL_LEVEL(RX_FILL_LEVEL),
  .RX_SECTION_EMPTY(RX_SECTION_EMPTY), .CLI_READY(CLI_READY), .TXD(TXD), .TX_EN(TX_EN),
  .PAUSE_ACTIVE(PAUSE_ACTIVE));

// [mpg_phy_model.sv]
// Purpose: PHY side receiver of the transmit octets
// Assumes: Data settles well before the next link clock rise
// Notes: Keeps the octets of the last finished frame
`timescale 1ns/1ps
module mpg_phy_model (
  output logic TX_CLK,
  input wire logic [7:0] TXD,
  input wire logic TX_EN,
  input wire logic GIG_MODE
);
  logic [7:0] cur[128];
  logic [7:0] last[128];
  logic [3:0] lo;
  logic half = 1'b0;
  logic was_en = 1'b0;
  int len = 0;
  int last_len = 0;
  int n_frames = 0;
  // Free running, phase offset so edges never meet SYS_CLK edges
  initial begin
    TX_CLK = 1'b0;
    #7;
    forever #80 TX_CLK = ~TX_CLK;
  end
  always @(posedge TX_CLK) begin
    if (TX_EN && GIG_MODE) begin
      cur[len[6:0]] = TXD;
      len++;
    end else if (TX_EN && !half) begin
      lo = TXD[3:0];
      half = 1'b1;
    end else if (TX_EN) begin
      cur[len[6:0]] = {TXD[3:0], lo};
      len++;
      half = 1'b0;
    end else if (was_en) begin
      last = cur;
      last_len = len;
      len = 0;
      half = 1'b0;
      n_frames++;
    end
    was_en = TX_EN;
  end
endmodule : mpg_phy_model

// [mpg_pkg.sv]
// Purpose: Types of the pause frame generator
// Assumes: Nothing beyond the defines header
// Notes: Carriers for transmit octets and pause requests
package mpg_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CLIENT, ST_PAUSE, ST_GAP} mpg_state_e;
  typedef struct packed {
    logic en;
    logic [7:0] data;
  } mpg_octet_s;
  typedef struct packed {
    logic xoff;
    logic xon;
  } mpg_req_s;
endpackage : mpg_pkg

// [tb_top.sv]
// Purpose: Self-checking bench of the pause frame generator
// Assumes: Idle link between tests
// Notes: Expected frames are built and CRC checked here
`timescale 1ns/1ps
module tb_top;
  import mpg_pkg::*;
  localparam logic [47:0] SA = 48'h0a0b0c0d0e0f;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic gig = 1'b1;
  logic fc = 1'b1;
  logic [3:0] req = 4'h0;
  logic [11:0] fill = 12'h000;
  logic [11:0] thr = 12'hfff;
  logic [7:0] txd;
  logic tx_en, pa, tx_clk;
  logic cli_rdy;
  mpg_octet_s cli = '0;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 SYS_CLK = ~SYS_CLK;
  mpg_phy_model i_mpg_phy_model (.TX_CLK(tx_clk), .TXD(txd), .TX_EN(tx_en), .GIG_MODE(gig));
  mpg_pause_gen i_mpg_pause_gen (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .TX_CLK(tx_clk), .GIG_MODE(gig),
    .FC_ENA(fc), .XOFF_REG(req[3]), .XON_REG(req[2]), .XOFF_PIN(req[1]), .XON_PIN(req[0]),
    .RX_FILL_LEVEL(fill), .RX_SECTION_EMPTY(thr), .PAUSE_QUANTA(16'h1234), .SRC_ADDR(SA),
    .CLI_TX(cli), .CLI_READY(cli_rdy), .TXD(txd), .TX_EN(tx_en), .PAUSE_ACTIVE(pa));
  ////////////////////////////////////////
  task check(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task wait_pa(logic v);
    for (int i = 0; i < 3000 && pa !== v; i++) @(negedge SYS_CLK);
    check("pause_active", {15'h0000, pa}, {15'h0000, v});
  endtask : wait_pa
  task automatic check_frame(logic [15:0] q);
    logic [7:0] e[72];
    logic [31:0] crc;
    logic [7:0] got;
    crc = 32'hffffffff;
    for (int i = 0; i < 72; i++) e[i] = (i < 7) ? 8'h55 : 8'h00;
    e[7] = 8'hd5;
    {e[8], e[9], e[10], e[11], e[12], e[13]} = 48'h0180c2000001;
    for (int i = 0; i < 6; i++) e[14+i] = SA[8*i+:8];
    {e[20], e[21], e[22], e[23]} = 32'h88080001;
    {e[24], e[25]} = q;
    for (int i = 8; i < 68; i++) begin
      crc = crc ^ {24'h000000, e[i]};
      for (int b = 0; b < 8; b++) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
    end
    {e[71], e[70], e[69], e[68]} = ~crc;
    check("frame length", 16'(i_mpg_phy_model.last_len), 16'h0048);
    for (int i = 0; i < 72; i++) begin
      got = i_mpg_phy_model.last[i];
      check($sformatf("octet %0d", i), {8'h00, got}, {8'h00, e[i]});
    end
  endtask : check_frame
  // Request cleared inside the last wanted frame, so no extra one follows
  task automatic run(logic [3:0] r, logic g, int frames, logic [15:0] q);
    int n0;
    @(negedge SYS_CLK);
    gig = g;
    n0 = i_mpg_phy_model.n_frames;
    req = r;
    for (int f = 1; f <= frames; f++) begin
      wait_pa(1'b1);
      if (f == frames) req = 4'h0;
      wait_pa(1'b0);
    end
    repeat (1500) @(negedge SYS_CLK);
    req = 4'h0;
    check("frame count", 16'(i_mpg_phy_model.n_frames - n0), 16'(frames));
    if (frames > 0) check_frame(q);
    $display("Test done request %b frames %0d", r, frames);
  endtask : run
  // Request raised inside a client frame must wait for its end
  task automatic run_client;
    int n0;
    @(negedge SYS_CLK);
    n0 = i_mpg_phy_model.n_frames;
    cli = '{en: 1'b1, data: 8'h5a};
    repeat (80) @(negedge SYS_CLK);
    req = 4'b1000;
    repeat (120) @(negedge SYS_CLK);
    check("ready in client frame", {15'h0000, cli_rdy}, 16'h0001);
    check("pause in client frame", {15'h0000, pa}, 16'h0000);
    cli = '0;
    wait_pa(1'b1);
    check("ready in pause frame", {15'h0000, cli_rdy}, 16'h0000);
    req = 4'h0;
    wait_pa(1'b0);
    repeat (1500) @(negedge SYS_CLK);
    check("frame count", 16'(i_mpg_phy_model.n_frames - n0), 16'h0002);
    check_frame(16'h1234);
    $display("Test done client frame then pause frame");
  endtask : run_client
  ////////////////////////////////////////
  initial begin
    repeat (5) @(negedge SYS_CLK);
    RST_N = 1'b1;
    repeat (10) @(negedge SYS_CLK);
    run(4'b1000, 1'b1, 2, 16'h1234);
    run(4'b0001, 1'b0, 1, 16'h0000);
    run(4'b0100, 1'b1, 1, 16'h0000);
    run(4'b0010, 1'b0, 1, 16'h1234);
    run_client();
    fill = 12'h100;
    thr = 12'h080;
    run(4'b0000, 1'b1, 1, 16'h1234);
    fc = 1'b0;
    run(4'b0010, 1'b1, 0, 16'h0000);
    print_verdict();
  end
endmodule : tb_top
